// ### verilog/ptm_defines.vh
`ifndef PTM_DEFINES_VH
`define PTM_DEFINES_VH

// Register byte offsets on the APB bus.
`define PTM_OFF_MODE_CTRL   8'h00
`define PTM_OFF_COUNT_LOW   8'h04
`define PTM_OFF_COUNT_HIGH  8'h08
`define PTM_OFF_CMP_A_LOW   8'h0c
`define PTM_OFF_CMP_A_HIGH  8'h10
`define PTM_OFF_PERIOD_LOW  8'h14
`define PTM_OFF_PERIOD_HIGH 8'h18
`define PTM_OFF_RUN_CTRL    8'h1c
`define PTM_OFF_FLAGS       8'h20

// Field positions in timer_mode_control.
`define PTM_MODE_MSB        7
`define PTM_MODE_LSB        6
`define PTM_ACT_MSB         5
`define PTM_ACT_LSB         4
`define PTM_INIT_BIT        3
`define PTM_INV_BIT         2
`define PTM_CAPSRC_BIT      1
`define PTM_CLRSEL_BIT      0

// Field positions in the run control register.
`define PTM_RUN_BIT         0
`define PTM_PAUSE_BIT       1
`define PTM_CKSEL_MSB       3
`define PTM_CKSEL_LSB       2

// Field positions in the flag register.
`define PTM_FLAG_A_BIT      0
`define PTM_FLAG_P_BIT      1

// Operating mode codes.
`define PTM_MODE_CMP        2'b00
`define PTM_MODE_CAP        2'b01
`define PTM_MODE_PWM        2'b10
`define PTM_MODE_TMR        2'b11

// Pin action codes.
`define PTM_ACT_0           2'b00
`define PTM_ACT_1           2'b01
`define PTM_ACT_2           2'b10
`define PTM_ACT_3           2'b11

// Counter clock selections and divider end counts.
`define PTM_CK_SYS          2'b00
`define PTM_CK_DIV4         2'b01
`define PTM_CK_DIV16        2'b10
`define PTM_CK_EXT          2'b11
`define PTM_DIV4_END        4'h3
`define PTM_DIV16_END       4'hf

// Reset values.
`define PTM_RST_BYTE        8'h00
`define PTM_RST_VAL10       10'h000
`define PTM_RST_CKSEL       2'b00

`endif

// ### verilog/ptm_timer.v
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defines.vh"

// What this block does
// - Mode field: 00 compare output, 01 capture, 10 PWM/single pulse, 11 timer.
// - Compare mode, on A match: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM mode action: 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode action: 00 rising, 01 falling, 10 both, 11 disabled.
// - Compare mode pin starts at initial level; same-level match shows nothing.
// - Run bit rising edge returns the pin to its initial level in compare mode.
// - Initial-level bit: pre-match level, or PWM active level; unused in timer mode.
// - Invert bit inverts the output pin; unused in timer mode.
// - Capture source: timer pins when 0, external clock pin when 1.
// - Clear select 1 clears on A match; 0 on P match or overflow.
// - Overflow clear happens only when the P value is all zero.
// - Clear select is ignored in PWM, single pulse and capture modes.
// - Counter readable only, low byte and two-bit high register.
// - Compare A value held in low byte and two-bit high register.
// - Compare P value held in low byte and two-bit high register.
// - With clear select 0 both match flags are raised, except the P flag in single pulse mode.
// - With clear select 1 in compare and timer modes only the A flag is raised.
// - In compare mode only A matches change the pin; P matches never do.
// - Timer mode counts and flags like compare mode but releases the pin.
// - Ten-bit up-counter compared against A and P values.
// - Run rise zeroes the counter; run fall stops and holds it.
module ptm_timer (
    // Clock and reset.
    input  wire        mclk_i,
    input  wire        sys_rst_i,
    // APB slave.
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // Timer pins.
    input  wire        timer_pin_zero_i,
    output reg         timer_pin_zero_o,
    output reg         timer_pin_zero_oe_n_o,
    input  wire        timer_pin_one_i,
    output reg         timer_pin_one_o,
    output reg         timer_pin_one_oe_n_o,
    input  wire        ext_timer_clock_pin_i,
    // Match flags.
    output reg         match_a_flag_o,
    output reg         match_p_flag_o
);

    // Registers visible to software.
    reg [7:0] timer_mode_control;
    reg [9:0] compare_a_value;
    reg [9:0] compare_p_value;
    reg       counter_run;
    reg       counter_pause;
    reg [1:0] clock_sel;
    reg       match_a_flag;
    reg       match_p_flag;

    // Internal state.
    reg [9:0] count_value;
    reg       run_prev;
    reg       pin_level;
    reg [3:0] div_count;
    reg       pin0_prev;
    reg       pin1_prev;
    reg       ext_prev;

    // Next values.
    reg [9:0] next_count;
    reg       next_pin_level;
    reg [31:0] next_rdata;
    reg       next_err;

    // Field views of the mode register.
    wire [1:0] op_mode_sel        = timer_mode_control[`PTM_MODE_MSB:`PTM_MODE_LSB];
    wire [1:0] pin_action_sel     = timer_mode_control[`PTM_ACT_MSB:`PTM_ACT_LSB];
    wire       out_initial_level  = timer_mode_control[`PTM_INIT_BIT];
    wire       out_invert         = timer_mode_control[`PTM_INV_BIT];
    wire       capture_source_sel = timer_mode_control[`PTM_CAPSRC_BIT];
    wire       clear_source_sel   = timer_mode_control[`PTM_CLRSEL_BIT];

    // Decoded modes.
    wire mode_cmp    = (op_mode_sel == `PTM_MODE_CMP);
    wire mode_cap    = (op_mode_sel == `PTM_MODE_CAP);
    wire mode_pwm    = (op_mode_sel == `PTM_MODE_PWM);
    wire mode_tmr    = (op_mode_sel == `PTM_MODE_TMR);
    wire mode_single = mode_pwm && (pin_action_sel == `PTM_ACT_3);

    // Bus access phase; the write lands at the edge where pready is sampled high.
    wire bus_access = psel_i && penable_i;
    wire bus_write  = bus_access && pready_o && pwrite_i;

    // Returns true when an access addresses the given offset.
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // Selects which edges of a pin count as capture events.
    function edge_ok;
        input [1:0] act;
        input       prev;
        input       cur;
        begin
            case (act)
                `PTM_ACT_0: edge_ok = !prev && cur;
                `PTM_ACT_1: edge_ok = prev && !cur;
                `PTM_ACT_2: edge_ok = prev ^ cur;
                default:    edge_ok = 1'b0;
            endcase
        end
    endfunction

    // External pin rising edge and run rising edge.
    wire ext_rise = !ext_prev && ext_timer_clock_pin_i;
    wire run_rise = counter_run && !run_prev;

    // Counter clock enable from the divider or the external pin.
    reg clk_en;
    always @*
    begin
        case (clock_sel)
            `PTM_CK_SYS:   clk_en = 1'b1;
            `PTM_CK_DIV4:  clk_en = (div_count[1:0] == `PTM_DIV4_END);
            `PTM_CK_DIV16: clk_en = (div_count == `PTM_DIV16_END);
            default:       clk_en = ext_rise;
        endcase
    end

    // A counting step happens only while running and not paused.
    wire tick = counter_run && !counter_pause && clk_en && !run_rise;

    // Comparators look at the value the counter would step to, so an all-zero
    // period compares against the wrap from 3ff to 000.
    wire [9:0] count_plus = count_value + 10'h001;
    wire       a_hit      = tick && (count_plus == compare_a_value);
    wire       p_hit      = tick && (count_plus == compare_p_value);

    // Clear select applies in compare and timer modes only.
    wire cmp_like  = mode_cmp || mode_tmr;
    wire use_a_clr = cmp_like && clear_source_sel;
    wire clr_a     = use_a_clr && a_hit;
    wire clr_p     = !use_a_clr && !mode_single && p_hit;

    // Flag events per mode.
    wire cap_edge_pins = edge_ok(pin_action_sel, pin0_prev, timer_pin_zero_i) ||
                         edge_ok(pin_action_sel, pin1_prev, timer_pin_one_i);
    wire cap_edge_ext  = edge_ok(pin_action_sel, ext_prev, ext_timer_clock_pin_i);
    wire cap_event     = mode_cap && (capture_source_sel ? cap_edge_ext : cap_edge_pins);
    wire set_a = mode_cap ? cap_event : a_hit;
    wire set_p = mode_single ? 1'b0 : (p_hit && !use_a_clr);

    // Next counter value.
    always @*
    begin
        if (run_rise)
            next_count = `PTM_RST_VAL10;
        else if (clr_a || clr_p)
            next_count = `PTM_RST_VAL10;
        else if (tick)
            next_count = count_plus;
        else
            next_count = count_value;
    end

    // Next pre-inversion level of the output pin.
    always @*
    begin
        next_pin_level = pin_level;
        if (mode_cmp)
        begin
            if (run_rise)
                next_pin_level = out_initial_level;
            else if (a_hit)
            begin
                case (pin_action_sel)
                    `PTM_ACT_1: next_pin_level = 1'b0;
                    `PTM_ACT_2: next_pin_level = 1'b1;
                    `PTM_ACT_3: next_pin_level = !pin_level;
                    default:    next_pin_level = pin_level;
                endcase
            end
        end
        else if (mode_pwm)
        begin
            case (pin_action_sel)
                `PTM_ACT_0: next_pin_level = !out_initial_level;
                `PTM_ACT_1: next_pin_level = out_initial_level;
                `PTM_ACT_2: next_pin_level = (next_count < compare_a_value) ? out_initial_level
                                                                             : !out_initial_level;
                default:    next_pin_level = (counter_run && !a_hit) ? out_initial_level
                                                                     : !out_initial_level;
            endcase
        end
    end

    // Read data multiplexer with an error for unmapped offsets.
    always @*
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (hit(paddr_i, `PTM_OFF_MODE_CTRL))
            next_rdata[7:0] = timer_mode_control;
        else if (hit(paddr_i, `PTM_OFF_COUNT_LOW))
            next_rdata[7:0] = count_value[7:0];
        else if (hit(paddr_i, `PTM_OFF_COUNT_HIGH))
            next_rdata[1:0] = count_value[9:8];
        else if (hit(paddr_i, `PTM_OFF_CMP_A_LOW))
            next_rdata[7:0] = compare_a_value[7:0];
        else if (hit(paddr_i, `PTM_OFF_CMP_A_HIGH))
            next_rdata[1:0] = compare_a_value[9:8];
        else if (hit(paddr_i, `PTM_OFF_PERIOD_LOW))
            next_rdata[7:0] = compare_p_value[7:0];
        else if (hit(paddr_i, `PTM_OFF_PERIOD_HIGH))
            next_rdata[1:0] = compare_p_value[9:8];
        else if (hit(paddr_i, `PTM_OFF_RUN_CTRL))
            next_rdata[3:0] = {clock_sel, counter_pause, counter_run};
        else if (hit(paddr_i, `PTM_OFF_FLAGS))
            next_rdata[1:0] = {match_p_flag, match_a_flag};
        else
            next_err = 1'b1;
    end

    // APB handshake: one wait cycle, then pready with registered data.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= bus_access && !pready_o;
            pslverr_o <= bus_access && !pready_o && next_err;
            prdata_o  <= (bus_access && !pready_o && !pwrite_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Software-written configuration; a capture loads compare A unless a write lands.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            timer_mode_control <= `PTM_RST_BYTE;
            compare_a_value    <= `PTM_RST_VAL10;
            compare_p_value    <= `PTM_RST_VAL10;
            clock_sel          <= `PTM_RST_CKSEL;
            counter_pause      <= 1'b0;
        end
        else
        begin
            if (bus_write && hit(paddr_i, `PTM_OFF_MODE_CTRL))
                timer_mode_control <= pwdata_i[7:0];
            if (bus_write && hit(paddr_i, `PTM_OFF_CMP_A_LOW))
                compare_a_value[7:0] <= pwdata_i[7:0];
            else if (bus_write && hit(paddr_i, `PTM_OFF_CMP_A_HIGH))
                compare_a_value[9:8] <= pwdata_i[1:0];
            else if (cap_event)
                compare_a_value <= count_value;
            if (bus_write && hit(paddr_i, `PTM_OFF_PERIOD_LOW))
                compare_p_value[7:0] <= pwdata_i[7:0];
            if (bus_write && hit(paddr_i, `PTM_OFF_PERIOD_HIGH))
                compare_p_value[9:8] <= pwdata_i[1:0];
            if (bus_write && hit(paddr_i, `PTM_OFF_RUN_CTRL))
            begin
                clock_sel     <= pwdata_i[`PTM_CKSEL_MSB:`PTM_CKSEL_LSB];
                counter_pause <= pwdata_i[`PTM_PAUSE_BIT];
            end
        end
    end

    // Run bit: software write first, then the single pulse stop, then the trigger.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            counter_run <= 1'b0;
        else if (bus_write && hit(paddr_i, `PTM_OFF_RUN_CTRL))
            counter_run <= pwdata_i[`PTM_RUN_BIT];
        else if (mode_single && a_hit)
            counter_run <= 1'b0;
        else if (mode_single && ext_rise)
            counter_run <= 1'b1;
    end

    // Software clear strobes for the two flags, shared by the flags and their outputs.
    wire clr_flag_a = bus_write && hit(paddr_i, `PTM_OFF_FLAGS) && pwdata_i[`PTM_FLAG_A_BIT];
    wire clr_flag_p = bus_write && hit(paddr_i, `PTM_OFF_FLAGS) && pwdata_i[`PTM_FLAG_P_BIT];

    // Sticky match flags; write one to clear, a new event wins over the clear.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
        end
        else
        begin
            if (set_a)
                match_a_flag <= 1'b1;
            else if (clr_flag_a)
                match_a_flag <= 1'b0;
            if (set_p)
                match_p_flag <= 1'b1;
            else if (clr_flag_p)
                match_p_flag <= 1'b0;
        end
    end

    // Counter, divider, edge history and pin level.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            count_value <= `PTM_RST_VAL10;
            run_prev    <= 1'b0;
            pin_level   <= 1'b0;
            div_count   <= 4'h0;
            pin0_prev   <= 1'b0;
            pin1_prev   <= 1'b0;
            ext_prev    <= 1'b0;
        end
        else
        begin
            count_value <= next_count;
            run_prev    <= counter_run;
            pin_level   <= next_pin_level;
            div_count   <= div_count + 4'h1;
            pin0_prev   <= timer_pin_zero_i;
            pin1_prev   <= timer_pin_one_i;
            ext_prev    <= ext_timer_clock_pin_i;
        end
    end

    // Registered pin drive; released in capture and timer modes.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            timer_pin_zero_o      <= 1'b0;
            timer_pin_one_o       <= 1'b0;
            timer_pin_zero_oe_n_o <= 1'b1;
            timer_pin_one_oe_n_o  <= 1'b1;
            match_a_flag_o        <= 1'b0;
            match_p_flag_o        <= 1'b0;
        end
        else
        begin
            timer_pin_zero_o      <= next_pin_level ^ out_invert;
            timer_pin_one_o       <= next_pin_level ^ out_invert;
            timer_pin_zero_oe_n_o <= !(mode_cmp || mode_pwm);
            timer_pin_one_oe_n_o  <= !(mode_cmp || mode_pwm);
            // The flag outputs take the next flag state, so a clear shows at once.
            match_a_flag_o        <= set_a || (match_a_flag && !clr_flag_a);
            match_p_flag_o        <= set_p || (match_p_flag && !clr_flag_p);
        end
    end

endmodule
`default_nettype wire

// ### dv/ptm_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_chk (
    // Clock, reset and APB.
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Pins and flags.
    input wire logic        timer_pin_zero_o,
    input wire logic        timer_pin_zero_oe_n_o,
    input wire logic        timer_pin_one_o,
    input wire logic        timer_pin_one_oe_n_o,
    input wire logic        match_p_flag_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] cfg;
    logic       run;
    logic       live;
    // Completed transfers and whether the address is a mapped register.
    wire acc = psel_i && penable_i && pready_o;
    wire wr  = acc && pwrite_i;
    wire map = paddr_i <= 8'h20 && paddr_i[1:0] == 2'b00;
    // Shadow of the mode byte and run bit, so pin checks know the setup.
    always @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg  <= 8'h00;
            run  <= 1'b0;
            live <= 1'b0;
        end
        else
        begin
            live <= 1'b1;
            if (wr && paddr_i == 8'h00)
                cfg <= pwdata_i[7:0];
            if (wr && paddr_i == 8'h1c)
                run <= pwdata_i[0];
        end
    end
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence run_rise_s;
        wr && paddr_i == 8'h1c && pwdata_i[0] && !run && cfg[7:6] == 2'b00;
    endsequence
    wait_state_a: assert property (setup_s ##1 (psel_i && penable_i) |-> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    bad_addr_a: assert property (acc |-> pslverr_o == !map)
        else $error("error response does not follow address map");
    high_pad_a: assert property (acc && !pwrite_i && paddr_i inside {8'h08, 8'h10, 8'h18} |-> prdata_o[31:2] == 0)
        else $error("unused high register bits not zero");
    byte_pad_a: assert property (acc && !pwrite_i && map |-> prdata_o[31:8] == 0)
        else $error("read data wider than a byte");
    pin_release_a: assert property (live && $stable(cfg) |-> timer_pin_zero_oe_n_o == cfg[6])
        else $error("pin drive does not follow mode");
    pins_same_a: assert property (timer_pin_zero_o == timer_pin_one_o && timer_pin_zero_oe_n_o == timer_pin_one_oe_n_o)
        else $error("the two timer pins differ");
    no_p_flag_a: assert property ($rose(match_p_flag_o) && $past(cfg[7]) == $past(cfg[6]) |-> !$past(cfg[0]))
        else $error("P flag raised with A clear selected");
    run_reset_a: assert property (run_rise_s |-> ##2 timer_pin_zero_o == (cfg[3] ^ cfg[2]))
        else $error("pin not back at initial level after run");
endmodule
bind ptm_timer ptm_timer_chk chk (.mclk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .timer_pin_zero_o, .timer_pin_zero_oe_n_o, .timer_pin_one_o,
    .timer_pin_one_oe_n_o, .match_p_flag_o);
`default_nettype wire

// ### dv/ptm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_model (
    // Timer side.
    input  wire logic oe0_n_i,
    input  wire logic out0_i,
    input  wire logic oe1_n_i,
    input  wire logic out1_i,
    // Levels the outside circuit puts on the lines.
    input  wire logic lvl_i,
    input  wire logic ext_i,
    // Resolved lines.
    output wire logic pin0_o,
    output wire logic pin1_o,
    output wire logic ext_o
);
    // A pin shows the timer level while the timer drives it, else the outside level.
    assign pin0_o = oe0_n_i ? lvl_i : out0_i;
    assign pin1_o = oe1_n_i ? lvl_i : out1_i;
    assign ext_o  = ext_i;
endmodule
`default_nettype wire

// ### dv/periodic_timer_compare_match_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defines.vh"
module periodic_timer_compare_match_tb;
    logic mclk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0, lvl = 0, ext = 0;
    logic [7:0] paddr = 0, a;
    logic [31:0] pwdata = 0, prdata, rd, r, seed = 32'd92043;
    logic pready, pslverr, p0o, p0e, p1o, p1e, p0i, p1i, exti, fa, fp, er, ini, inv, clr, src;
    logic [1:0] act;
    int error_cnt = 0, n_compared = 0;
    always #4 mclk_i = ~mclk_i;
    ptm_timer uut (.mclk_i, .sys_rst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .timer_pin_zero_i(p0i), .timer_pin_zero_o(p0o), .timer_pin_zero_oe_n_o(p0e),
        .timer_pin_one_i(p1i), .timer_pin_one_o(p1o), .timer_pin_one_oe_n_o(p1e),
        .ext_timer_clock_pin_i(exti), .match_a_flag_o(fa), .match_p_flag_o(fp));
    ptm_pin_model pins (.oe0_n_i(p0e), .out0_i(p0o), .oe1_n_i(p1e), .out1_i(p1o), .lvl_i(lvl), .ext_i(ext),
        .pin0_o(p0i), .pin1_o(p1i), .ext_o(exti));
    // Repeatable pseudo-random source.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Pin level in compare mode after k matches.
    function automatic logic pin_exp(logic [1:0] ac, logic i0, logic iv, int k);
        logic l;
        l = i0;
        for (int i = 0; i < k; i++)
            l = ac == 2'b01 ? 1'b0 : ac == 2'b10 ? 1'b1 : ac == 2'b11 ? !l : l;
        return l ^ iv;
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; holds the request until ready is sampled high.
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("ready", pready, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Lets one edge pass first, so a flag clear that has just landed is seen.
    task automatic waitf(logic p);
        int n;
        n = 0;
        @(posedge mclk_i);
        while ((p ? fp : fa) !== 1'b1 && n < 3000)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk("flag wait", n < 3000, 1);
    endtask
    // Stops the counter, sets the mode byte, then clears flags a pin change at the switch may raise.
    task automatic setup(logic [7:0] m);
        apb(1'b1, `PTM_OFF_RUN_CTRL, 0);
        apb(1'b1, `PTM_OFF_MODE_CTRL, {24'h0, m});
        apb(1'b1, `PTM_OFF_FLAGS, 3);
    endtask
    initial
    begin
        #400000;
        error_cnt++;
        end_sim();
    end
    initial
    begin
        repeat (6) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Reset values, with the unmapped place after the last register.
        for (int k = 0; k <= 36; k += 4)
        begin
            apb(1'b0, 8'(k), 0);
            chk("reset value", rd, 0);
            chk("error", er, k == 36);
        end
        apb(1'b1, 8'h24, 32'hff);
        chk("unmapped write", er, 1);
        // Random compare values read back; count registers ignore writes.
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            a = 8'h0c + 8'(4 * (i % 4));
            apb(1'b1, a, r);
            apb(1'b0, a, 0);
            chk("compare reg", rd, r & (a[2] ? 32'hff : 32'h3));
            apb(1'b1, 8'(4 + 4 * (i % 2)), r);
            apb(1'b0, 8'(4 + 4 * (i % 2)), 0);
            chk("count reg", rd, 0);
        end
        // Compare mode: every pin action, both clear sources.
        for (int c = 0; c < 8; c++)
        begin
            r = rnd();
            act = c[1:0];
            clr = c[2];
            ini = r[0];
            inv = r[1];
            setup({`PTM_MODE_CMP, act, ini, inv, 1'b0, clr});
            apb(1'b1, `PTM_OFF_CMP_A_LOW, 6 + r[3:2]);
            apb(1'b1, `PTM_OFF_CMP_A_HIGH, 0);
            apb(1'b1, `PTM_OFF_PERIOD_LOW, clr ? 2 : 12);
            apb(1'b1, `PTM_OFF_PERIOD_HIGH, 0);
            apb(1'b1, `PTM_OFF_RUN_CTRL, 1);
            repeat (2) @(posedge mclk_i);
            chk("pin start", p0o, ini ^ inv);
            waitf(0);
            chk("pin first", p0o, pin_exp(act, ini, inv, 1));
            if (!clr)
                waitf(1);
            apb(1'b1, `PTM_OFF_FLAGS, 1);
            waitf(0);
            chk("pin second", p0o, pin_exp(act, ini, inv, 2));
            chk("P flag", fp, !clr);
            apb(1'b0, `PTM_OFF_COUNT_LOW, 0);
            if (clr)
                chk("cleared by A", rd < 6 + r[3:2], 1);
            else
                chk("cleared by P", rd < 12, 1);
        end
        // Timer mode with P zero: pin released, wrap at full range, stop holds.
        setup({`PTM_MODE_TMR, 2'b11, 4'b0000});
        apb(1'b1, `PTM_OFF_CMP_A_LOW, 3);
        apb(1'b1, `PTM_OFF_PERIOD_LOW, 0);
        apb(1'b1, `PTM_OFF_RUN_CTRL, 1);
        waitf(0);
        chk("pin released", p0e, 1);
        chk("no early P", fp, 0);
        waitf(1);
        apb(1'b1, `PTM_OFF_RUN_CTRL, 0);
        apb(1'b0, `PTM_OFF_COUNT_LOW, 0);
        r = rd;
        repeat (5) @(posedge mclk_i);
        apb(1'b0, `PTM_OFF_COUNT_LOW, 0);
        chk("count held", rd, r);
        // PWM forced levels.
        for (int c = 0; c < 2; c++)
        begin
            r = rnd();
            setup({`PTM_MODE_PWM, 1'b0, c[0], r[0], r[1], 2'b00});
            repeat (2) @(posedge mclk_i);
            chk("forced level", p0o, (c[0] ? r[0] : !r[0]) ^ r[1]);
        end
        // Capture: every edge choice, random source, other source must not trigger.
        for (int c = 0; c < 4; c++)
        begin
            src = rnd() & 1;
            setup({`PTM_MODE_CAP, c[1:0], 2'b00, src, 1'b0});
            apb(1'b1, `PTM_OFF_RUN_CTRL, 1);
            if (src) lvl <= 1'b1; else ext <= 1'b1;
            repeat (8) @(posedge mclk_i);
            chk("other source", fa, 0);
            if (src) ext <= 1'b1; else lvl <= 1'b1;
            repeat (8) @(posedge mclk_i);
            chk("rise capture", fa, c == 0 || c == 2);
            apb(1'b1, `PTM_OFF_FLAGS, 1);
            ext <= 1'b0;
            lvl <= 1'b0;
            repeat (8) @(posedge mclk_i);
            chk("fall capture", fa, c == 1 || c == 2);
        end
        // Single pulse: the external pin starts it, an A match ends it and stops the counter.
        setup({`PTM_MODE_PWM, 2'b11, 4'b1000});
        apb(1'b1, `PTM_OFF_CMP_A_LOW, 5);
        apb(1'b1, `PTM_OFF_CMP_A_HIGH, 0);
        ext <= 1'b1;
        repeat (3) @(posedge mclk_i);
        chk("pulse active", p0o, 1);
        waitf(0);
        chk("pulse end", p0o, 0);
        apb(1'b0, `PTM_OFF_RUN_CTRL, 0);
        chk("run after pulse", rd, 0);
        end_sim();
    end
endmodule
`default_nettype wire
